// ### design/mscp_port.sv
// Serial configuration port: decodes the host's 1/2/4-lane serial
// stream, holds the control registers and queues channel writes.
// Assumes the serial clock is far slower than sys_clk_i (at least
// four system cycles per serial phase); all pins are asynchronous.

// Notes on behaviour
// - Mode field bits 2:1 pick 2-wire, 3-wire, 2-bit or 4-bit width.
// - Reset leaves the port in single-bit 2-wire mode.
// - 2-wire mode uses lane 0 both ways; lane 1 carries no data.
// - 3-wire mode takes input on lane 0 and drives reads on lane 2.
// - In 1-bit and 2-bit modes lane 3 is the abort input.
// - Lanes 1 and 2, when free of data, serve as ramp control inputs.
// - Single-bit modes allow MSB-first, LSB-first and abort.
// - 2-bit mode takes two bits per rising edge, same phases.
// - In 2-bit mode lane 0 has even bits, lane 1 odd bits.
// - 4-bit mode takes four bits per edge; no abort then.
// - Capture on rising serial edges, launch reads after falling ones.
// - Serial clock may stall high or low without losing place.
// - Channel enables act as soon as their byte is written.
// - Function-config bytes wait in the buffer for an update strobe; mode and LSB-first bits act at transfer end.
// - Channel enables steer which channels take a channel write.
// - Instruction byte: bit 7 read, bits 4:0 address, 6:5 ignored.
// - Abort high ends the transfer, registers kept; restart when low.
// - Channel-select bit 0 sets LSB-first, instruction byte included.
// - Chip select high suspends the transfer and floats the lanes.
module mscp_port
    import mscp_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Serial pins from the host
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic [3:0] sdio_i,
    output logic [3:0] sdio_o,
    output logic [3:0] sdio_oe_n_o,
    // Update strobe pin
    input wire logic io_update_i,
    // Active configuration
    output logic [3:0] chan_en_o,
    output logic [1:0] port_mode_o,
    output logic lsb_first_o,
    output logic [23:0] function_config_one_o,
    output logic [15:0] function_config_two_o,
    output logic [1:0] amplitude_ramp_control_o,
    // Channel register writes
    output logic chan_wr_valid_o,
    input wire logic chan_wr_ready_i,
    output logic [3:0] chan_wr_mask_o,
    output logic [4:0] chan_wr_addr_o,
    output logic [1:0] chan_wr_byte_o,
    output logic [7:0] chan_wr_data_o,
    output logic chan_wr_overflow_o
);
    // Synchronised pins
    logic [6:0] sync_w;
    logic sclk_s;
    logic csn_s;
    logic [3:0] sdio_s;
    logic upd_s;

    logic sclk_prev_q;
    logic upd_prev_q;
    logic rise;
    logic fall;
    logic active;
    logic abort;

    mscp_state_t state_q;
    logic [2:0] edge_q;
    logic [1:0] byte_q;
    logic [7:0] shift_q;
    logic [7:0] byte_d;
    logic [4:0] addr_q;
    logic [2:0] len_q;
    logic [1:0] mode_q;
    logic lsb_q;
    logic boundary_q;

    logic [2:0] lanes;
    logic [2:0] nb;
    logic [2:0] grp;
    logic last_edge;
    logic last_byte;
    logic [1:0] bytenum;
    logic step;
    logic byte_done;
    logic xfer_end;

    logic [7:0] csr_q;
    logic [23:0] fr1_buf_q;
    logic [15:0] fr2_buf_q;
    logic [7:0] rd_byte;
    logic [3:0] drive_mask;

    logic pend_q;
    logic [CHAN_WORD_W-1:0] pend_word_q;
    logic fifo_in_ready;
    logic [CHAN_WORD_W-1:0] fifo_out;

    mscp_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i({io_update_i, sdio_i, chip_select_n_i, sclk_i}),
        .q_o(sync_w)
    );

    assign sclk_s = sync_w[0];
    assign csn_s = sync_w[1];
    assign sdio_s = sync_w[5:2];
    assign upd_s = sync_w[6];

    // Edge detection on the sampled serial clock and strobe
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_prev_q <= 1'b0;
            upd_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            upd_prev_q <= upd_s;
        end
    end

    // Edges count only while selected, so a stall keeps position
    assign rise = sclk_s && !sclk_prev_q;
    assign fall = !sclk_s && sclk_prev_q;
    assign active = !csn_s;
    assign abort = (mode_q != MODE_4B) && sdio_s[3];

    // Geometry of the current width
    assign lanes = lane_count(mode_q);
    assign nb = 3'((4'h8 / {1'b0, lanes}) - 4'h1);
    assign grp = lsb_q ? edge_q : 3'(nb - edge_q);
    assign last_edge = edge_q == nb;
    assign last_byte = {1'b0, byte_q} == 3'(len_q - 3'h1);
    assign bytenum = lsb_q ? byte_q : 2'(len_q - 3'h1 - {1'b0, byte_q});
    assign step = rise && active && !abort;

    // Lane k of group g lands on bit g*lanes+k, so lane 0 holds even bits
    always_comb begin
        int idx;
        idx = 0;
        byte_d = shift_q;
        for (int k = 0; k < 4; k++) begin
            if (k < int'(lanes)) begin
                idx = int'(grp) * int'(lanes) + k;
                byte_d[idx[2:0]] = sdio_s[k];
            end
        end
    end

    assign byte_done = step && last_edge && (state_q == ST_WRITE);
    assign xfer_end = step && last_edge && last_byte && (state_q != ST_INSTR);

    // Transfer sequencer
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_INSTR;
            edge_q <= 3'h0;
            byte_q <= 2'h0;
            shift_q <= 8'h00;
            addr_q <= 5'h00;
            len_q <= 3'h1;
        end else if (abort) begin
            // Only completed bytes have been stored; drop the partial one
            state_q <= ST_INSTR;
            edge_q <= 3'h0;
            byte_q <= 2'h0;
        end else if (step) begin
            shift_q <= byte_d;
            edge_q <= last_edge ? 3'h0 : edge_q + 3'h1;
            if (last_edge) begin
                unique case (state_q)
                    ST_INSTR: begin
                        // Bits 6:5 of the instruction are ignored
                        addr_q <= byte_d[INSTR_ADDR_W-1:0];
                        len_q <= reg_len(byte_d[INSTR_ADDR_W-1:0]);
                        byte_q <= 2'h0;
                        state_q <= byte_d[INSTR_READ_BIT] ? ST_READ : ST_WRITE;
                    end
                    ST_WRITE, ST_READ: begin
                        byte_q <= byte_q + 2'h1;
                        if (last_byte) begin
                            state_q <= ST_INSTR;
                        end
                    end
                    default: state_q <= ST_INSTR;
                endcase
            end
        end
    end

    // Width and ordering change only between transfers; one cycle late so
    // a write to the mode field in the final byte is already stored
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boundary_q <= 1'b0;
            mode_q <= MODE_1B_2W;
            lsb_q <= 1'b0;
        end else begin
            boundary_q <= xfer_end || abort;
            if (boundary_q) begin
                mode_q <= csr_q[CS_MODE_LO +: 2];
                lsb_q <= csr_q[CS_LSB_FIRST_BIT];
            end
        end
    end

    // Port buffer: each completed byte is stored at once
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            csr_q <= CHANNEL_SELECT_RST;
            fr1_buf_q <= FUNC_CFG_ONE_RST;
            fr2_buf_q <= FUNC_CFG_TWO_RST;
        end else if (byte_done) begin
            unique case (addr_q)
                ADDR_CHANNEL_SELECT: csr_q <= byte_d & CS_WRITE_MASK;
                ADDR_FUNC_CFG_ONE: fr1_buf_q[8*bytenum +: 8] <= byte_d;
                ADDR_FUNC_CFG_TWO: begin
                    if (bytenum[1] == 1'b0) begin
                        fr2_buf_q[8*bytenum[0] +: 8] <= byte_d;
                    end
                end
                default: ;
            endcase
        end
    end

    // Active copies follow the buffer only on an update strobe
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            function_config_one_o <= FUNC_CFG_ONE_RST;
            function_config_two_o <= FUNC_CFG_TWO_RST;
        end else if (upd_s && !upd_prev_q) begin
            function_config_one_o <= fr1_buf_q;
            function_config_two_o <= fr2_buf_q;
        end
    end

    // Status of the port itself
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chan_en_o <= CHANNEL_SELECT_RST[CS_CHAN_EN_LO +: 4];
            port_mode_o <= MODE_1B_2W;
            lsb_first_o <= 1'b0;
        end else begin
            chan_en_o <= csr_q[CS_CHAN_EN_LO +: 4];
            port_mode_o <= mode_q;
            lsb_first_o <= lsb_q;
        end
    end

    // Lanes free of data double as ramp inputs
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            amplitude_ramp_control_o <= 2'h0;
        end else begin
            amplitude_ramp_control_o[0] <= (mode_q == MODE_1B_2W || mode_q == MODE_1B_3W)
                && sdio_s[1];
            amplitude_ramp_control_o[1] <= (mode_q == MODE_1B_2W || mode_q == MODE_2B)
                && sdio_s[2];
        end
    end

    // Read source; channel registers live outside and read as zero
    always_comb begin
        unique case (addr_q)
            ADDR_CHANNEL_SELECT: rd_byte = csr_q;
            ADDR_FUNC_CFG_ONE: rd_byte = fr1_buf_q[8*bytenum +: 8];
            ADDR_FUNC_CFG_TWO: rd_byte = bytenum[0] ? fr2_buf_q[15:8] : fr2_buf_q[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    // Lanes that carry read data in each width
    always_comb begin
        unique case (mode_q)
            MODE_1B_2W: drive_mask = 4'h1;
            MODE_1B_3W: drive_mask = 4'h4;
            MODE_2B: drive_mask = 4'h3;
            default: drive_mask = 4'hF;
        endcase
    end

    // Read launch after each falling edge; host owns the lanes until then
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdio_o <= 4'h0;
            sdio_oe_n_o <= 4'hF;
        end else if (state_q != ST_READ || !active || abort) begin
            sdio_oe_n_o <= 4'hF;
        end else if (fall) begin
            sdio_oe_n_o <= ~drive_mask;
            if (mode_q == MODE_1B_3W) begin
                sdio_o <= {1'b0, rd_byte[grp], 2'h0};
            end else begin
                for (int k = 0; k < 4; k++) begin
                    sdio_o[k] <= (k < int'(lanes))
                        ? rd_byte[3'(int'(grp) * int'(lanes) + k)] : 1'b0;
                end
            end
        end
    end

    // One channel byte waits for the FIFO; another arriving meanwhile is
    // lost and flagged, as a serial host cannot be stalled
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'b0;
            pend_word_q <= '0;
            chan_wr_overflow_o <= 1'b0;
        end else if (byte_done && addr_q > ADDR_FUNC_CFG_TWO) begin
            if (!pend_q || fifo_in_ready) begin
                pend_q <= 1'b1;
                pend_word_q <= {csr_q[CS_CHAN_EN_LO +: 4], addr_q, bytenum, byte_d};
            end else begin
                chan_wr_overflow_o <= 1'b1;
            end
        end else if (fifo_in_ready) begin
            pend_q <= 1'b0;
        end
    end

    mscp_fifo #(
        .WIDTH(CHAN_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(pend_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pend_word_q),
        .out_valid_o(chan_wr_valid_o),
        .out_ready_i(chan_wr_ready_i),
        .out_data_o(fifo_out)
    );

    assign chan_wr_mask_o = fifo_out[18:15];
    assign chan_wr_addr_o = fifo_out[14:10];
    assign chan_wr_byte_o = fifo_out[9:8];
    assign chan_wr_data_o = fifo_out[7:0];
endmodule

// ### design/mscp_pkg.sv
// Constants shared by the multilane serial configuration port.
// Assumes a 250 MHz system clock that oversamples all serial pins.
package mscp_pkg;

    // Port width selections held in the channel-select mode field
    typedef enum logic [1:0] {
        MODE_1B_2W = 2'h0,
        MODE_1B_3W = 2'h1,
        MODE_2B = 2'h2,
        MODE_4B = 2'h3
    } mscp_mode_t;

    // Transfer phases of the serial sequencer
    typedef enum logic [1:0] {
        ST_INSTR,
        ST_WRITE,
        ST_READ
    } mscp_state_t;

    // Register addresses
    localparam logic [4:0] ADDR_CHANNEL_SELECT = 5'h00;
    localparam logic [4:0] ADDR_FUNC_CFG_ONE = 5'h01;
    localparam logic [4:0] ADDR_FUNC_CFG_TWO = 5'h02;

    // Reset values
    localparam logic [7:0] CHANNEL_SELECT_RST = 8'hF0;
    localparam logic [23:0] FUNC_CFG_ONE_RST = 24'h000000;
    localparam logic [15:0] FUNC_CFG_TWO_RST = 16'h0000;

    // Channel-select field layout; bit 3 must stay zero
    localparam int CS_LSB_FIRST_BIT = 0;
    localparam int CS_MODE_LO = 1;
    localparam int CS_CHAN_EN_LO = 4;
    localparam logic [7:0] CS_WRITE_MASK = 8'hF7;

    // Instruction byte layout
    localparam int INSTR_READ_BIT = 7;
    localparam int INSTR_ADDR_W = 5;

    // Queued channel write: {mask, addr, byte number, data}
    localparam int CHAN_WORD_W = 4 + INSTR_ADDR_W + 2 + 8;

    // Data lanes in use for a given port width
    function automatic logic [2:0] lane_count(input logic [1:0] mode);
        unique case (mode)
            MODE_2B: lane_count = 3'h2;
            MODE_4B: lane_count = 3'h4;
            default: lane_count = 3'h1;
        endcase
    endfunction

    // Register length in bytes by address
    function automatic logic [2:0] reg_len(input logic [4:0] addr);
        unique case (addr)
            5'h00: reg_len = 3'h1;
            5'h01, 5'h03, 5'h06: reg_len = 3'h3;
            5'h02, 5'h05, 5'h07: reg_len = 3'h2;
            default: reg_len = 3'h4;
        endcase
    endfunction

endpackage

// ### design/mscp_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence.
module mscp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Levels
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// ### design/mscp_fifo.sv
// Synchronous FIFO with a registered output stage.
// Assumes DEPTH is a power of two; both sides use valid/ready.
module mscp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr_q;
    logic [PW-1:0] rptr_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;

    assign in_ready_o = count_q != FULL;
    assign push = in_valid_i && in_ready_o;
    // Refill the output stage when it is empty or being taken
    assign pop = (count_q != '0) && (!out_valid_o || out_ready_i);

    // Storage array
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr_q] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) wptr_q <= wptr_q + 1'b1;
            if (pop) rptr_q <= rptr_q + 1'b1;
            count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Output register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else if (pop) begin
            out_valid_o <= 1'b1;
            out_data_o <= mem[rptr_q];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end
endmodule

// ### verif/mscp_port_monitor.sv
// Concurrent checks on the serial configuration port's pins.
// Assumes it is bound to every instance of mscp_port.
module mscp_port_monitor
    import mscp_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Serial pins
    input wire logic chip_select_n_i,
    input wire logic [3:0] sdio_i,
    input wire logic [3:0] sdio_oe_n_o,
    input wire logic io_update_i,
    // Active configuration
    input wire logic [1:0] port_mode_o,
    input wire logic [23:0] function_config_one_o,
    input wire logic [15:0] function_config_two_o,
    input wire logic [1:0] amplitude_ramp_control_o,
    // Channel write queue
    input wire logic chan_wr_valid_o,
    input wire logic chan_wr_ready_i,
    input wire logic [3:0] chan_wr_mask_o,
    input wire logic [4:0] chan_wr_addr_o,
    input wire logic [1:0] chan_wr_byte_o,
    input wire logic [7:0] chan_wr_data_o,
    input wire logic chan_wr_overflow_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Lane 1 quiet and free long enough to pass the synchronisers
    sequence s_lane1_quiet;
        ($stable(sdio_i[1]) && $stable(port_mode_o) && port_mode_o < 2'h2) [*6];
    endsequence

    // Strobe pin rose a few cycles ago, low well before
    sequence s_strobe_recent;
        $past(io_update_i, 2) && !$past(io_update_i, 9);
    endsequence

    // Lane enables by chip select and port width
    a_deselect_floats: assert property (chip_select_n_i [*6] |-> sdio_oe_n_o == 4'hF)
        else $error("lanes driven while deselected");
    a_lane3_input: assert property (port_mode_o != MODE_4B |-> sdio_oe_n_o[3])
        else $error("lane 3 driven outside 4-bit width");
    a_lane1_unused: assert property (port_mode_o < 2'h2 |-> sdio_oe_n_o[1])
        else $error("lane 1 driven in single-bit width");
    a_sdo_lane2: assert property (port_mode_o == MODE_1B_3W |-> sdio_oe_n_o[0])
        else $error("lane 0 driven in 3-wire width");
    a_lane2_unused: assert property (!port_mode_o[0] |-> sdio_oe_n_o[2])
        else $error("lane 2 driven while free");

    // Ramp control follows free lanes only
    a_ramp_follow: assert property (s_lane1_quiet |-> amplitude_ramp_control_o[0] == sdio_i[1])
        else $error("ramp bit 0 does not follow lane 1");
    a_ramp_gone_4b: assert property ((port_mode_o == MODE_4B) [*3] |-> !amplitude_ramp_control_o)
        else $error("ramp control active in 4-bit width");

    // Active copies move only after a strobe
    a_cfg_on_strobe: assert property ($changed({function_config_one_o, function_config_two_o}) |-> s_strobe_recent)
        else $error("active config changed without strobe");

    // Queued write stands until taken; loss is sticky
    a_queue_holds: assert property (chan_wr_valid_o && !chan_wr_ready_i |=> chan_wr_valid_o
        && $stable({chan_wr_mask_o, chan_wr_addr_o, chan_wr_byte_o, chan_wr_data_o}))
        else $error("queued write changed before taken");
    a_overflow_sticky: assert property ($rose(chan_wr_overflow_o) |=> chan_wr_overflow_o [*8])
        else $error("overflow flag dropped");
endmodule

bind mscp_port mscp_port_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
    .sys_clk_i, .rst_n_i, .chip_select_n_i, .sdio_i, .sdio_oe_n_o, .io_update_i,
    .port_mode_o, .function_config_one_o, .function_config_two_o,
    .amplitude_ramp_control_o, .chan_wr_valid_o, .chan_wr_ready_i, .chan_wr_mask_o,
    .chan_wr_addr_o, .chan_wr_byte_o, .chan_wr_data_o, .chan_wr_overflow_o
);

// ### verif/mscp_host.sv
// Serial master model standing in for the host controller.
// Assumes the bench resolves each lane from the port's enables.
module mscp_host (
    // Serial pins toward the port
    output logic sclk_o,
    output logic cs_n_o,
    output logic [3:0] drv_o,
    // Resolved lane levels
    input wire logic [3:0] lane_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] mode_q;
    logic [1:0] ramp_q;
    logic [3:0] dat_q;
    logic lsb_q;
    logic stall_q;
    logic susp_q;
    logic abort_q;

    // Idle link: clock stands low, port deselected
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        {mode_q, lsb_q, stall_q, susp_q, abort_q} = '0;
        ramp_q = 2'h3;
        dat_q = 4'h5;
    end

    // Lane 3 kept low outside 4-bit so a width switch never aborts
    always_comb begin
        drv_o = dat_q;
        if (mode_q != 2'h3) drv_o[3] = abort_q;
        if (mode_q < 2'h2) drv_o[1] = ramp_q[0];
        if (!mode_q[0]) drv_o[2] = ramp_q[1];
    end

    // One byte: data set on the fall, taken on the rise
    task automatic put_byte(input logic [7:0] b, output logic [7:0] r);
        int w;
        int g;
        w = (mode_q == 2'h3) ? 4 : (mode_q == 2'h2) ? 2 : 1;
        r = 8'h00;
        for (int e = 0; e < 8 / w; e++) begin
            g = lsb_q ? e : 8 / w - 1 - e;
            for (int k = 0; k < w; k++) dat_q[k] = b[g * w + k];
            #32;
            if (stall_q && e == 1) #96;
            if (susp_q && e == 1) begin
                cs_n_o = 1'b1;
                dat_q = ~dat_q;
                repeat (2) begin
                    #32 sclk_o = 1'b1;
                    #32 sclk_o = 1'b0;
                end
                dat_q = ~dat_q;
                #32 cs_n_o = 1'b0;
                #32;
            end
            sclk_o = 1'b1;
            for (int k = 0; k < w; k++) r[g * w + k] = lane_i[(mode_q == 2'h1) ? 2 : k];
            #32;
            if (stall_q && e == 1) #96;
            sclk_o = 1'b0;
        end
    endtask

    // Instruction then n data bytes, order set by the bit ordering
    task automatic xfer(input logic [7:0] ins, input int n, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic [7:0] r;
        int j;
        rd = 32'h0;
        cs_n_o = 1'b0;
        #32;
        put_byte(ins, r);
        for (int i = 0; i < n; i++) begin
            j = lsb_q ? i : n - 1 - i;
            put_byte(ins[7] ? ~wd[j * 8 +: 8] : wd[j * 8 +: 8], r);
            rd[j * 8 +: 8] = r;
        end
        #32;
        cs_n_o = 1'b1;
        dat_q = ~dat_q;
        #32;
    endtask

    // Abort pulse on lane 3 while selected
    task automatic abort_xfer();
        cs_n_o = 1'b0;
        abort_q = 1'b1;
        #64 abort_q = 1'b0;
        #64 cs_n_o = 1'b1;
        #32;
    endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the serial configuration port.
// Assumes the host model and port monitor are compiled with it.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, rst_n_i, io_update_i, chan_wr_ready_i, sclk, cs_n;
    logic [3:0] drv, lane, sdio_o, oe_n, chan_en_o, chan_wr_mask_o;
    logic [1:0] port_mode_o, ramp, chan_wr_byte_o, er;
    logic lsb_first_o, chan_wr_valid_o, chan_wr_overflow_o;
    logic [23:0] cfg1;
    logic [15:0] cfg2;
    logic [4:0] chan_wr_addr_o;
    logic [7:0] chan_wr_data_o;
    logic [18:0] ew;
    logic [31:0] rd;
    int err_total, check_count;

    // Port where it drives, else host
    assign lane = (sdio_o & ~oe_n) | (drv & oe_n);

    // 250 MHz system clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    mscp_port #(.FIFO_DEPTH(8)) u_dut (
        .sys_clk_i, .rst_n_i, .sclk_i(sclk), .chip_select_n_i(cs_n), .sdio_i(lane),
        .sdio_o, .sdio_oe_n_o(oe_n), .io_update_i, .chan_en_o, .port_mode_o, .lsb_first_o,
        .function_config_one_o(cfg1), .function_config_two_o(cfg2),
        .amplitude_ramp_control_o(ramp), .chan_wr_valid_o, .chan_wr_ready_i,
        .chan_wr_mask_o, .chan_wr_addr_o, .chan_wr_byte_o, .chan_wr_data_o,
        .chan_wr_overflow_o
    );

    mscp_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .drv_o(drv), .lane_i(lane));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Strobe held long enough to cross the synchroniser
    task automatic strobe();
        io_update_i = 1'b1;
        repeat (8) @(posedge sys_clk_i);
        #1 io_update_i = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        #1;
    endtask

    // Write channel_select with bit 3 set; it must read back clear
    task automatic set_mode(input logic [7:0] cs_val);
        u_host.xfer(8'h00, 1, {24'h0, cs_val | 8'h08}, rd);
        chk("chan_en", cs_val[7:4], chan_en_o);
        u_host.mode_q = cs_val[2:1];
        u_host.lsb_q = cs_val[0];
        repeat (8) @(posedge sys_clk_i);
        #1;
        er = ~{cs_val[1], cs_val[2]};
        chk("mode", cs_val[2:1], port_mode_o);
        chk("lsb", cs_val[0], lsb_first_o);
        chk("ramp", er, ramp);
        u_host.xfer(8'h80, 1, 32'h0, rd);
        chk("csr", cs_val, rd);
    endtask

    // Bounded wait for a queued write
    task automatic wait_valid();
        int t;
        t = 0;
        while (chan_wr_valid_o !== 1'b1 && t < 40) begin
            @(posedge sys_clk_i);
            #1;
            t++;
        end
        if (t == 40) begin
            err_total++;
            results();
        end
    endtask

    // Main sequence
    initial begin
        err_total = 0;
        check_count = 0;
        rst_n_i = 1'b0;
        io_update_i = 1'b0;
        chan_wr_ready_i = 1'b0;
        repeat (5) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk("chan_en", 32'hF, chan_en_o);
        chk("mode", 32'h0, port_mode_o);
        chk("oe_n", 32'hF, oe_n);
        u_host.xfer(8'h80, 1, 32'h0, rd);
        chk("csr", 32'hF0, rd);
        u_host.xfer(8'h61, 3, 32'hA1B2C3, rd);
        chk("cfg1 early", 32'h0, cfg1);
        strobe();
        chk("cfg1", 32'hA1B2C3, cfg1);
        u_host.xfer(8'hE1, 3, 32'h0, rd);
        chk("fr1", 32'hA1B2C3, rd);
        $display("test two-wire done");
        set_mode(8'h32);
        u_host.xfer(8'h81, 3, 32'h0, rd);
        chk("fr1", 32'hA1B2C3, rd);
        set_mode(8'h31);
        u_host.xfer(8'h81, 3, 32'h0, rd);
        chk("fr1", 32'hA1B2C3, rd);
        $display("test single-bit done");
        set_mode(8'h55);
        u_host.stall_q = 1'b1;
        u_host.xfer(8'h02, 2, 32'hA5C3, rd);
        u_host.stall_q = 1'b0;
        u_host.xfer(8'h82, 2, 32'h0, rd);
        chk("fr2", 32'hA5C3, rd);
        u_host.xfer(8'h01, 0, 32'h0, rd);
        u_host.abort_xfer();
        u_host.xfer(8'h81, 3, 32'h0, rd);
        chk("fr1", 32'hA1B2C3, rd);
        strobe();
        chk("cfg2", 32'hA5C3, cfg2);
        $display("test two-bit done");
        repeat (3) u_host.xfer(8'h04, 4, 32'h11223344, rd);
        chk("overflow", 32'h1, chan_wr_overflow_o);
        for (int i = 0; i < 10; i++) begin
            wait_valid();
            ew = {4'h5, 5'h04, 2'(i % 4), 8'(8'h44 - 8'h11 * (i % 4))};
            chk("wr word", ew, {chan_wr_mask_o, chan_wr_addr_o, chan_wr_byte_o,
                chan_wr_data_o});
            chan_wr_ready_i = 1'b1;
            @(posedge sys_clk_i);
            #1 chan_wr_ready_i = 1'b0;
        end
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk("valid", 32'h0, chan_wr_valid_o);
        $display("test channel queue done");
        set_mode(8'h16);
        u_host.susp_q = 1'b1;
        u_host.xfer(8'h01, 3, 32'h5E6F70, rd);
        u_host.susp_q = 1'b0;
        u_host.xfer(8'h81, 3, 32'h0, rd);
        chk("fr1", 32'h5E6F70, rd);
        $display("test four-bit done");
        results();
    end
endmodule
